// [design/fsc_norm.sv]
// Purpose: normalize, denormalize and pack one result word
// Assumes: purely combinational, registered by the caller
// Notes: no rounding; bits shifted out on the right are dropped
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_norm
  import fsc_pkg::*;
(
  // raw result
  input wire fsc_res_t res,
  // packed result
  output logic [31:0] word,
  output logic tiny
);
  logic [4:0] lz;
  logic signed [10:0] room;
  logic [10:0] rsh;
  logic [4:0] lsh;
  logic [23:0] sig_f;
  logic signed [9:0] exp_f;

  always_comb begin
    lz = 5'h18;
    for (int i = 0; i < 24; i++) begin
      if (res.sig[i]) begin
        lz = 5'(23 - i);
      end
    end
    room = {res.exp[9], res.exp} + `FSC_EMIN_MAG;
    rsh = 11'h000;
    lsh = 5'h00;
    sig_f = res.sig;
    exp_f = res.exp;
    tiny = 1'b0;
    if (room < 0) begin
      rsh = 11'(-room);
      exp_f = `FSC_EMIN;
      sig_f = (rsh >= 11'h018) ? 24'h000000 : (res.sig >> rsh[4:0]);
    end else begin
      lsh = ({6'h00, lz} < room) ? lz : room[4:0];
      sig_f = res.sig << lsh;
      exp_f = res.exp - {5'h00, lsh};
    end
    if (res.nan) begin
      word = `FSC_QNAN;
    end else if (res.exact_zero) begin
      word = {res.rnd_down, 31'h00000000};
    end else if (sig_f == 24'h000000) begin
      word = {res.sign, 31'h00000000};
      tiny = (res.sig != 24'h000000);
    end else if (exp_f > $signed(`FSC_EMAX)) begin
      word = {res.sign, `FSC_EXP_ALL1, 23'h000000};
    end else if (sig_f[23]) begin
      word = {res.sign, exp_f[7:0] + `FSC_BIAS, sig_f[22:0]};
    end else begin
      word = {res.sign, 8'h00, sig_f[22:0]};
      tiny = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [design/fsc_pkg.sv]
// Purpose: shared types of the classify and denormalize unit
// Assumes: nothing beyond the constants header
// Notes: class is one-hot
package fsc_pkg;
  typedef struct packed {
    logic snan;
    logic qnan;
    logic inf;
    logic norm;
    logic denorm;
    logic zero;
  } fsc_cls_t;

  typedef struct packed {
    logic sign;
    logic signed [9:0] exp;
    logic [23:0] sig;
  } fsc_unpk_t;

  typedef struct packed {
    logic sign;
    logic signed [9:0] exp;
    logic [23:0] sig;
    logic nan;
    logic exact_zero;
    logic rnd_down;
  } fsc_res_t;
endpackage

// [design/fsc_regs.svh]
// Purpose: constants for the single-precision classify and denormalize unit
// Assumes: 32-bit word, sign/exponent/fraction packing
// Notes: signed true exponents are carried in 10 bits, two's complement
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH
`define FSC_SIGN_BIT 31
`define FSC_EXP_MSB 30
`define FSC_EXP_LSB 23
`define FSC_FRAC_MSB 22
`define FSC_BIAS 8'h7F
`define FSC_BIAS_W 10'h07F
`define FSC_EXP_ALL1 8'hFF
`define FSC_EMIN 10'h382
`define FSC_EMIN_MAG 11'h07E
`define FSC_EMAX 10'h07F
`define FSC_EXP_SPECIAL 10'h080
`define FSC_QNAN 32'h7FC00000
`define FSC_RST_WORD 32'h00000000
`endif

// [design/fsc_top.sv]
// Purpose: classify operands and pack results in single precision
// Assumes: one core clock, synchronous active-low reset
// Notes: class and unpack outputs are combinational, result one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_top
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operands
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic op_valid,
  input wire logic op_two,
  // operand classes and unpacked fields
  output fsc_cls_t cls_a,
  output fsc_cls_t cls_b,
  output fsc_unpk_t unpk_a,
  output fsc_unpk_t unpk_b,
  output logic eq_ab,
  // raw result
  input wire logic res_valid,
  input wire fsc_res_t res,
  // packed result and flags
  output logic out_valid_r,
  output logic [31:0] out_word_r,
  output logic flag_underflow_r,
  output logic flag_denorm_op_r
);
  logic [31:0] norm_word;
  logic norm_tiny;
  logic out_valid_nxt;
  logic [31:0] out_word_nxt;
  logic flag_underflow_nxt;
  logic flag_denorm_op_nxt;

  function automatic fsc_cls_t classify(input logic [31:0] w);
    fsc_cls_t c;
    logic [7:0] e;
    logic fz;
    e = w[`FSC_EXP_MSB:`FSC_EXP_LSB];
    fz = (w[`FSC_FRAC_MSB:0] == 23'h000000);
    c = '0;
    c.zero = (e == 8'h00) && fz;
    c.denorm = (e == 8'h00) && !fz;
    c.norm = (e != 8'h00) && (e != `FSC_EXP_ALL1);
    c.inf = (e == `FSC_EXP_ALL1) && fz;
    c.qnan = (e == `FSC_EXP_ALL1) && !fz && w[`FSC_FRAC_MSB];
    c.snan = (e == `FSC_EXP_ALL1) && !fz && !w[`FSC_FRAC_MSB];
    return c;
  endfunction

  function automatic fsc_unpk_t unpack(input logic [31:0] w);
    fsc_unpk_t u;
    logic [7:0] e;
    e = w[`FSC_EXP_MSB:`FSC_EXP_LSB];
    u.sign = w[`FSC_SIGN_BIT];
    u.sig = {(e != 8'h00), w[`FSC_FRAC_MSB:0]};
    if (e == 8'h00) begin
      u.exp = `FSC_EMIN;
    end else if (e == `FSC_EXP_ALL1) begin
      u.exp = `FSC_EXP_SPECIAL;
    end else begin
      u.exp = {2'b00, e} - `FSC_BIAS_W;
    end
    return u;
  endfunction

  // same-cycle classification
  always_comb begin
    cls_a = classify(opa);
    cls_b = classify(opb);
    unpk_a = unpack(opa);
    unpk_b = unpack(opb);
    if (cls_a.qnan || cls_a.snan || cls_b.qnan || cls_b.snan) begin
      eq_ab = 1'b0;
    end else if (cls_a.zero && cls_b.zero) begin
      eq_ab = 1'b1;
    end else begin
      eq_ab = (opa == opb);
    end
  end

  fsc_norm u_norm (
    .res(res),
    .word(norm_word),
    .tiny(norm_tiny)
  );

  // result register
  always_comb begin
    out_valid_nxt = res_valid;
    out_word_nxt = res_valid ? norm_word : out_word_r;
    flag_underflow_nxt = res_valid && norm_tiny;
    flag_denorm_op_nxt = op_valid && (cls_a.denorm || (op_two && cls_b.denorm));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_word_r <= `FSC_RST_WORD;
      flag_underflow_r <= 1'b0;
      flag_denorm_op_r <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_word_r <= out_word_nxt;
      flag_underflow_r <= flag_underflow_nxt;
      flag_denorm_op_r <= flag_denorm_op_nxt;
    end
  end

  // checks
  logic ordinary;
  assign ordinary = res_valid && !res.nan && !res.exact_zero;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SIGN: assert property (
    ordinary |=> out_word_r[`FSC_SIGN_BIT] == $past(res.sign))
    else $error("result sign differs from raw sign");
  AST_IMPLIED: assert property (
    cls_a.norm |-> unpk_a.sig == {1'b1, opa[22:0]})
    else $error("normal operand lacks implied integer bit");
  AST_BIAS: assert property (
    cls_a.norm |-> unpk_a.exp == $signed({2'b00, opa[30:23]}) - 10'sh07F)
    else $error("true exponent is not biased exponent minus 127");
  AST_NORMALIZE: assert property (
    ordinary && res.sig[23:22] == 2'b01 && res.exp > -10'sh078 && res.exp < 10'sh078
    |=> out_word_r[30:23] == 8'($past(res.exp) + 10'sh07E) && out_word_r[22:0] == {$past(res.sig[21:0]), 1'b0})
    else $error("single leading zero not normalized");
  AST_NORMAL_RANGE: assert property (
    cls_a.norm == (opa[30:23] >= 8'h01 && opa[30:23] <= 8'hFE))
    else $error("normal class range wrong");
  AST_DENORM_OP: assert property (
    cls_a.denorm |-> unpk_a.sig[23] == 1'b0 && unpk_a.exp == -10'sh07E && opa[22:0] != 23'h0)
    else $error("denormal operand unpacked wrongly");
  AST_ZERO_EQ: assert property (
    opa[30:0] == 31'h0 && opb[30:0] == 31'h0 |-> eq_ab)
    else $error("signed zeros do not compare equal");
  AST_ZERO_SIGN: assert property (
    res_valid && !res.nan && res.exact_zero |=> out_word_r == {$past(res.rnd_down), 31'h0})
    else $error("exact zero sign wrong");
  AST_GRADUAL: assert property (
    ordinary && res.exp == -10'sh081 && res.sig[23]
    |=> out_word_r[30:0] == {8'h00, 3'b001, $past(res.sig[22:3])})
    else $error("gradual underflow shift wrong");
  AST_FLUSH: assert property (
    ordinary && res.exp <= -10'sh096 |=> out_word_r[30:0] == 31'h0 && flag_underflow_r == ($past(res.sig) != 24'h0))
    else $error("fully shifted result not zero");
  AST_PREFER_NORMAL: assert property (
    ordinary && res.sig != 24'h0 && res.exp >= -10'sh067 && res.exp <= 10'sh07F |=> out_word_r[30:23] != 8'h00)
    else $error("denormal produced where normal fits");
  AST_UNDERFLOW: assert property (
    out_valid_r && out_word_r[30:23] == 8'h00 && out_word_r[22:0] != 23'h0 |-> flag_underflow_r)
    else $error("denormal result without underflow flag");
  AST_DENORM_FLAG: assert property (
    op_valid && cls_a.denorm |=> flag_denorm_op_r ##1 (!flag_denorm_op_r || $past(op_valid, 1)))
    else $error("denormal operand flag missing");
  AST_INF: assert property (
    ordinary && res.sig[23] && res.exp > 10'sh07F |=> out_word_r[30:0] == {8'hFF, 23'h0})
    else $error("overflow not encoded as infinity");
  AST_NAN_CLASS: assert property (
    (cls_a.qnan || cls_a.snan) == (opa[30:23] == 8'hFF && opa[22:0] != 23'h0))
    else $error("NaN class wrong");
  AST_NO_SNAN: assert property (
    out_valid_r && out_word_r[30:23] == 8'hFF && out_word_r[22:0] != 23'h0 |-> out_word_r[22])
    else $error("signaling NaN produced");
  AST_FIELDS: assert property (
    cls_a.inf |-> opa[30:23] == 8'hFF && opa[22:0] == 23'h0)
    else $error("field placement wrong");
  AST_ONEHOT: assert property (
    $onehot(cls_a) && $onehot(cls_b))
    else $error("class not one-hot");
  AST_SIGN_UNPK: assert property (
    unpk_a.sign == opa[31] && unpk_b.sign == opb[31])
    else $error("unpacked sign differs from sign bit");
  AST_IMPLIED_B: assert property (
    cls_b.norm |-> unpk_b.sig == {1'b1, opb[22:0]})
    else $error("normal operand b lacks implied integer bit");
  AST_BIAS_B: assert property (
    cls_b.norm |-> unpk_b.exp == $signed({2'b00, opb[30:23]}) - 10'sh07F)
    else $error("operand b exponent bias wrong");
  AST_NORMAL_RANGE_B: assert property (
    cls_b.norm == (opb[30:23] >= 8'h01 && opb[30:23] <= 8'hFE))
    else $error("operand b normal class range wrong");
  AST_DENORM_CLASS_B: assert property (
    cls_b.denorm == (opb[30:23] == 8'h00 && opb[22:0] != 23'h000000))
    else $error("operand b denormal class wrong");
  AST_ZERO_NE: assert property (
    cls_a.zero && !cls_b.zero |-> !eq_ab)
    else $error("zero compares equal to nonzero");
  AST_NAN_NE: assert property (
    cls_a.qnan || cls_a.snan || cls_b.qnan || cls_b.snan |-> !eq_ab)
    else $error("NaN compares equal");
  AST_QUIET_BIT: assert property (
    cls_a.qnan || cls_a.snan |-> cls_a.qnan == opa[22])
    else $error("quiet and signaling NaN swapped");
  AST_QNAN_OUT: assert property (
    res_valid && res.nan |=> out_word_r == `FSC_QNAN)
    else $error("NaN result not the quiet NaN word");
  AST_UF_PULSE: assert property (
    flag_underflow_r |-> out_valid_r)
    else $error("underflow flag without result");
  AST_UF_NORMAL: assert property (
    out_valid_r && out_word_r[30:23] != 8'h00 |-> !flag_underflow_r)
    else $error("underflow flag on normal or special result");
  AST_DENORM_B: assert property (
    op_valid && op_two && cls_b.denorm |=> flag_denorm_op_r)
    else $error("operand b denormal flag missing");
  AST_NO_DENORM_OP: assert property (
    !op_valid || !(cls_a.denorm || (op_two && cls_b.denorm)) |=> !flag_denorm_op_r)
    else $error("denormal operand flag without denormal source");

  COV_DENORM_RES: cover property (out_valid_r && flag_underflow_r && out_word_r[22:0] != 23'h0);
  COV_FLUSH: cover property (out_valid_r && flag_underflow_r && out_word_r[30:0] == 31'h0);
  COV_DENORM_OP: cover property (flag_denorm_op_r);
  COV_ZERO_EQ: cover property (eq_ab && opa != opb);
  COV_INF_RES: cover property (out_valid_r && out_word_r[30:0] == {8'hFF, 23'h000000});
endmodule
`default_nettype wire

// [tb/fsc_pipe_model.sv]
// Purpose: stand-in for the arithmetic pipeline that feeds raw results
// Assumes: one result per request, presented for one cycle
// Notes: idle result lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fsc_pipe_model
  import fsc_pkg::*;
(
  // clock
  input wire logic clk,
  // raw result
  output logic res_valid,
  output fsc_res_t res
);
  initial begin
    res_valid = 1'b0;
    res = '0;
  end
  // present one result, then scramble the released lines
  task automatic drive(input fsc_res_t r);
    @(posedge clk);
    #1;
    res_valid = 1'b1;
    res = r;
    @(posedge clk);
    #1;
    res_valid = 1'b0;
    res = ~r;
  endtask
endmodule
`default_nettype wire

// [tb/test_fsc_top.sv]
// Purpose: self-checking bench for the classify and denormalize unit
// Assumes: pipeline model drives raw results
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module test_fsc_top;
  import fsc_pkg::*;
  logic clk;
  logic rst_n;
  logic [31:0] opa;
  logic [31:0] opb;
  logic op_valid;
  logic op_two;
  fsc_cls_t cls_a;
  fsc_cls_t cls_b;
  fsc_unpk_t unpk_a;
  fsc_unpk_t unpk_b;
  logic eq_ab;
  logic res_valid;
  fsc_res_t res;
  logic out_valid_r;
  logic [31:0] out_word_r;
  logic flag_underflow_r;
  logic flag_denorm_op_r;
  int n_fail = 0;
  int total_checks = 0;
  localparam logic [31:0] CW [9] = '{32'h0, 32'h80000000, 32'h1, 32'h43322000, 32'h00800000,
    32'h7F7FFFFF, 32'hFF800000, 32'h7FC00000, 32'h7F800001};
  localparam logic [5:0] CC [9] = '{6'h01, 6'h01, 6'h02, 6'h04, 6'h04, 6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [34:0] CU [6] = '{{1'b0, 10'h382, 24'h0}, {1'b1, 10'h382, 24'h0},
    {1'b0, 10'h382, 24'h1}, {1'b0, 10'h007, 24'hB22000}, {1'b0, 10'h382, 24'h800000},
    {1'b0, 10'h07F, 24'hFFFFFF}};
  localparam logic [37:0] RQ [10] = '{{1'b0, 10'h37F, 24'hAB8000, 3'h0}, {1'b0, 10'h007, 24'hB22000, 3'h0},
    {1'b0, 10'h008, 24'h591000, 3'h0}, {1'b0, 10'h382, 24'h400000, 3'h0}, {1'b0, 10'h36A, 24'h800000, 3'h0},
    {1'b0, 34'h0, 3'h4}, {1'b0, 34'h0, 3'h3}, {1'b1, 34'h0, 3'h2}, {1'b1, 10'h080, 24'h800000, 3'h0},
    {1'b0, 10'h382, 24'h800000, 3'h0}};
  localparam logic [31:0] RW [10] = '{32'h00157000, 32'h43322000, 32'h43322000, 32'h00400000, 32'h0,
    32'h7FC00000, 32'h80000000, 32'h0, 32'hFF800000, 32'h00800000};
  localparam logic [9:0] RU = 10'b0000011001;
  fsc_pipe_model pipe (.clk(clk), .res_valid(res_valid), .res(res));
  fsc_top dut (.clk(clk), .rst_n(rst_n), .opa(opa), .opb(opb), .op_valid(op_valid), .op_two(op_two),
    .cls_a(cls_a), .cls_b(cls_b), .unpk_a(unpk_a), .unpk_b(unpk_b), .eq_ab(eq_ab),
    .res_valid(res_valid), .res(res), .out_valid_r(out_valid_r), .out_word_r(out_word_r),
    .flag_underflow_r(flag_underflow_r), .flag_denorm_op_r(flag_denorm_op_r));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [37:0] got, input logic [37:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk(38'({out_valid_r, flag_underflow_r, flag_denorm_op_r}), 38'h0, "reset flags");
    chk(38'(out_word_r), 38'h0, "reset word");
    $display("reset test done");
  endtask
  task automatic t_class();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1;
      opa = CW[i];
      opb = CW[i];
      #1;
      chk(38'(cls_a), 38'(CC[i]), "class a");
      chk(38'(cls_b), 38'(CC[i]), "class b");
      chk(38'(eq_ab), 38'(CC[i] < 6'h10), "equal same word");
      if (i < 6) begin
        chk(38'(unpk_a), 38'(CU[i]), "unpack a");
        chk(38'(unpk_b), 38'(CU[i]), "unpack b");
      end
    end
    @(posedge clk);
    #1;
    opb = 32'h80000000;
    opa = 32'h0;
    #1;
    chk(38'(eq_ab), 38'h1, "signed zeros");
    @(posedge clk);
    #1;
    opa = 32'h3F800000;
    #1;
    chk(38'(eq_ab), 38'h0, "unequal");
    $display("class test done");
  endtask
  task automatic t_result();
    for (int i = 0; i < 10; i++) begin
      pipe.drive(RQ[i]);
      chk(38'(out_valid_r), 38'h1, "valid");
      chk(38'(out_word_r), 38'(RW[i]), "word");
      chk(38'(flag_underflow_r), 38'(RU[i]), "underflow");
      @(posedge clk);
      #1;
      chk(38'({out_valid_r, flag_underflow_r}), 38'h0, "pulse end");
      chk(38'(out_word_r), 38'(RW[i]), "word hold");
    end
    $display("result test done");
  endtask
  task automatic dop(input logic [31:0] a, input logic [31:0] b, input logic two, input logic v, input logic e);
    @(posedge clk);
    #1;
    opa = a;
    opb = b;
    op_two = two;
    op_valid = v;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    chk(38'(flag_denorm_op_r), 38'(e), "denormal operand");
  endtask
  task automatic t_denorm_op();
    dop(32'h1, 32'h3F800000, 1'b0, 1'b1, 1'b1);
    dop(32'h3F800000, 32'h1, 1'b0, 1'b1, 1'b0);
    dop(32'h3F800000, 32'h1, 1'b1, 1'b1, 1'b1);
    dop(32'h80000000, 32'h0, 1'b1, 1'b1, 1'b0);
    dop(32'h1, 32'h1, 1'b1, 1'b0, 1'b0);
    $display("denormal operand test done");
  endtask
  initial begin
    rst_n = 1'b0;
    opa = '0;
    opb = '0;
    op_valid = 1'b0;
    op_two = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    @(posedge clk);
    t_class();
    t_result();
    t_denorm_op();
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    finish_test();
  end
  initial begin
    #20000;
    n_fail++;
    $display("wrong value at %0t: watchdog", $time);
    finish_test();
  end
endmodule
`default_nettype wire
